// ===== verilog/fhc_pkg.sv
`default_nettype none
package fhc_pkg;

  // clock rate and cycle conversion (least times round up, never below one cycle)
  localparam int CLK_MHZ = 20;
  localparam int CNT_W = 10;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // bus and recovery times in ns
  localparam int T_SETUP_NS = 20;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int T_HOLD_NS = 20;
  localparam int T_BUSY_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int T_RECOVER_NS = 20000;

  localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(cyc_up(T_SETUP_NS));
  localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(cyc_up(T_WP_NS));
  localparam logic [CNT_W-1:0] ACC_CNT = CNT_W'(cyc_up(T_ACC_NS));
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(cyc_up(T_HOLD_NS));
  localparam logic [CNT_W-1:0] BUSY_CNT = CNT_W'(cyc_up(T_BUSY_NS));
  localparam logic [CNT_W-1:0] RP_CNT = CNT_W'(cyc_up(T_RP_NS));
  localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(cyc_up(T_RECOVER_NS));

  // unlock addresses, word and byte addressing
  localparam logic [11:0] UNLOCK1_WORD = 12'h555;
  localparam logic [11:0] UNLOCK2_WORD = 12'h2aa;
  localparam logic [11:0] UNLOCK1_BYTE = 12'haaa;
  localparam logic [11:0] UNLOCK2_BYTE = 12'h555;

  // command cycle data
  localparam logic [7:0] CD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CD_PROGRAM = 8'ha0;
  localparam logic [7:0] CD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CD_SUSPEND = 8'hb0;
  localparam logic [7:0] CD_RESUME = 8'h30;
  localparam logic [7:0] CD_BYPASS = 8'h20;
  localparam logic [7:0] CD_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] CD_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] CD_RESET = 8'hf0;

  // status bit positions on the data bus lines
  localparam int DATA_POLL_STATUS_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;

  typedef enum logic [3:0] {
    CMD_READ = 4'h0,
    CMD_PROGRAM = 4'h1,
    CMD_BYP_ENTER = 4'h2,
    CMD_BYP_EXIT = 4'h3,
    CMD_CHIP_ERASE = 4'h4,
    CMD_SECTOR_ERASE = 4'h5,
    CMD_SUSPEND = 4'h6,
    CMD_RESUME = 4'h7,
    CMD_SW_RESET = 4'h8,
    CMD_HW_RESET = 4'h9
  } fhc_cmd_t;

  typedef enum logic [1:0] {
    POLL_PIN = 2'h0,
    POLL_DATA = 2'h1,
    POLL_TOGGLE = 2'h2
  } fhc_poll_t;

endpackage
`default_nettype wire

// ===== verilog/fhc_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module fhc_bus_cycle #(
  parameter int ADDR_W = 21
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // cycle request
  input wire logic start_i,
  input wire logic write_i,
  input wire logic byte_mode_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] data_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  // flash pins
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [15:0] dq_o,
  output logic [1:0] dq_oe_o,
  input wire logic [15:0] dq_i
);

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SETUP = 2'b01,
    PH_PULSE = 2'b11,
    PH_HOLD = 2'b10
  } fhc_phase_t;

  fhc_phase_t phase_reg;
  logic [fhc_pkg::CNT_W-1:0] cnt_reg;
  logic write_reg;
  logic byte_reg;

  assign busy_o = (phase_reg != PH_IDLE);

  // phase sequencer; ce drops before either strobe and rises only after both are high
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_reg <= PH_IDLE;
      cnt_reg <= '0;
      write_reg <= 1'b0;
      byte_reg <= 1'b0;
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      done_o <= 1'b0;
      addr_o <= '0;
      dq_o <= 16'h0000;
      dq_oe_o <= 2'h0;
    end else begin
      done_o <= 1'b0;
      case (phase_reg)
        PH_IDLE: begin
          if (start_i) begin
            ce_n_o <= 1'b0; // [RL14]
            addr_o <= addr_i; // [RL13]
            write_reg <= write_i;
            byte_reg <= byte_mode_i;
            if (write_i) begin
              dq_o <= data_i; // [RL13]
              dq_oe_o <= byte_mode_i ? 2'h1 : 2'h3; // upper lane idle in byte mode [RL10]
            end
            cnt_reg <= fhc_pkg::SETUP_CNT - 1'b1;
            phase_reg <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          if (cnt_reg == '0) begin
            if (write_reg) begin
              we_n_o <= 1'b0; // [RL14]
              cnt_reg <= fhc_pkg::WP_CNT - 1'b1;
            end else begin
              oe_n_o <= 1'b0; // [RL14]
              cnt_reg <= fhc_pkg::ACC_CNT - 1'b1;
            end
            phase_reg <= PH_PULSE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        PH_PULSE: begin
          if (cnt_reg == '0) begin
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            cnt_reg <= fhc_pkg::HOLD_CNT - 1'b1;
            phase_reg <= PH_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        PH_HOLD: begin
          if (cnt_reg == '0) begin
            ce_n_o <= 1'b1; // deselect between cycles keeps the part in standby [RL12]
            dq_oe_o <= 2'h0;
            done_o <= 1'b1;
            phase_reg <= PH_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: phase_reg <= PH_IDLE;
      endcase
    end
  end

  // read capture at the end of the access window
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 16'h0000;
    end else if (phase_reg == PH_PULSE && cnt_reg == '0 && !write_reg) begin
      rdata_o <= byte_reg ? {8'h00, dq_i[7:0]} : dq_i; // [RL10]
    end
  end

endmodule // fhc_bus_cycle
`default_nettype wire

// ===== verilog/fhc_flash_host.sv
// Function
// (RL1) In bypass mode a program takes two write cycles, otherwise four.
// (RL2) A program sequence starts the internal program algorithm; host just waits.
// (RL3) An erase sequence starts the internal erase algorithm; host just waits.
// (RL4) Completion is seen on the ready/busy pin, data polling or toggle bit.
// (RL5) After program or erase completes, array reads and new commands resume.
// (RL6) Erase may be suspended; other sectors read or programmed; then resumed.
// (RL7) The hardware reset pin aborts any operation and returns to array read.
// (RL8) Protected sectors refuse program and erase and keep their contents.
// (RL9) Writes are ignored while the supply is low during power transitions.
// (RL10) Word mode uses all sixteen data lines, byte mode only the low eight.
// (RL11) The device sleeps automatically when addresses stay unchanged a while.
// (RL12) The host may deselect the device into standby until selected again.
// (RL13) Each write cycle latches address and data into the command register.
// (RL14) Chip select, write strobe and output enable are separate active-low controls.
// (RL15) The array holds small boot sectors at top or bottom plus large sectors.
// (RL16) Erase covers whole array or chosen sectors, leaving the others intact.
// (RL17) Temporary unprotect allows changes to locked sectors without unlocking them.
// (RL18) Ready/busy shows busy through the algorithm, ready when done or suspended.
// (RL19) An incomplete or invalid sequence is discarded and array read resumes.
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_host #(
  parameter int ADDR_W = 21
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // command port
  input wire logic CMD_VALID_I,
  input wire logic [3:0] CMD_I,
  input wire logic [ADDR_W-1:0] CMD_ADDR_I,
  input wire logic [15:0] CMD_DATA_I,
  input wire logic BYTE_MODE_I,
  input wire logic [1:0] POLL_SEL_I,
  output logic CMD_READY_O,
  output logic DONE_O,
  output logic CMD_ERR_O,
  output logic [15:0] RDATA_O,
  output logic BUSY_O,
  output logic BYPASS_O,
  output logic SUSPENDED_O,
  // flash pins
  output logic FLASH_CE_N_O,
  output logic FLASH_WE_N_O,
  output logic FLASH_OE_N_O,
  output logic FLASH_RESET_N_O,
  output logic FLASH_BYTE_N_O,
  output logic [ADDR_W-1:0] FLASH_ADDR_O,
  output logic [15:0] DATA_BUS_LINES_O,
  output logic [1:0] DATA_BUS_LINES_OE_O,
  input wire logic [15:0] DATA_BUS_LINES_I,
  input wire logic READY_BUSY_N_PIN_I
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR = 3'b001,
    ST_PWAIT = 3'b011,
    ST_POLL = 3'b010,
    ST_RD = 3'b110,
    ST_RST = 3'b111,
    ST_REC = 3'b101
  } fhc_state_t;

  fhc_state_t state_reg;
  fhc_pkg::fhc_cmd_t op_reg;
  fhc_pkg::fhc_cmd_t cmd_in;
  fhc_pkg::fhc_poll_t poll_sel_reg;
  logic [2:0] idx_reg;
  logic [fhc_pkg::CNT_W-1:0] wait_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [15:0] data_reg;
  logic byte_mode_reg, bypass_reg, suspended_reg, erasing_reg;
  logic have_prev_reg, prev_tog_reg, done_reg, err_reg, reset_n_reg;
  logic [15:0] rdata_reg;
  logic [2:0] seq_len;
  logic [ADDR_W-1:0] seq_addr, u1, u2, eng_addr;
  logic [7:0] seq_data;
  logic [15:0] eng_wdata, eng_rdata;
  logic legal, take_idle, take_susp, wr_last, embedded, poll_hit, fin;
  logic eng_start, eng_busy, eng_done, eng_free, pin_mode;

  assign cmd_in = fhc_pkg::fhc_cmd_t'(CMD_I);
  assign u1 = byte_mode_reg ? ADDR_W'(fhc_pkg::UNLOCK1_BYTE) : ADDR_W'(fhc_pkg::UNLOCK1_WORD);
  assign u2 = byte_mode_reg ? ADDR_W'(fhc_pkg::UNLOCK2_BYTE) : ADDR_W'(fhc_pkg::UNLOCK2_WORD);
  assign pin_mode = (poll_sel_reg == fhc_pkg::POLL_PIN);
  assign eng_free = !eng_busy && !eng_done;

  // write sequence table per command
  always_comb begin
    seq_len = 3'd1;
    seq_addr = u1;
    seq_data = fhc_pkg::CD_RESET;
    case (op_reg)
      fhc_pkg::CMD_PROGRAM: begin
        seq_len = bypass_reg ? 3'd2 : 3'd4; // [RL1]
        case (bypass_reg ? idx_reg + 3'd2 : idx_reg)
          3'd0: seq_data = fhc_pkg::CD_UNLOCK1;
          3'd1: begin seq_addr = u2; seq_data = fhc_pkg::CD_UNLOCK2; end
          3'd2: seq_data = fhc_pkg::CD_PROGRAM;
          default: begin seq_addr = addr_reg; seq_data = data_reg[7:0]; end
        endcase
      end
      fhc_pkg::CMD_CHIP_ERASE, fhc_pkg::CMD_SECTOR_ERASE, fhc_pkg::CMD_BYP_ENTER: begin
        seq_len = (op_reg == fhc_pkg::CMD_BYP_ENTER) ? 3'd3 : 3'd6;
        case (idx_reg)
          3'd0, 3'd3: seq_data = fhc_pkg::CD_UNLOCK1;
          3'd1, 3'd4: begin seq_addr = u2; seq_data = fhc_pkg::CD_UNLOCK2; end
          3'd2: begin
            seq_data = (op_reg == fhc_pkg::CMD_BYP_ENTER) ? fhc_pkg::CD_BYPASS
                                                          : fhc_pkg::CD_ERASE_SETUP;
          end
          default: begin
            if (op_reg == fhc_pkg::CMD_SECTOR_ERASE) begin
              seq_addr = addr_reg; // sector address picks the one to erase [RL16]
              seq_data = fhc_pkg::CD_SECTOR_ERASE;
            end else begin
              seq_data = fhc_pkg::CD_CHIP_ERASE; // [RL16]
            end
          end
        endcase
      end
      fhc_pkg::CMD_BYP_EXIT: begin
        seq_len = 3'd2;
        seq_data = (idx_reg == 3'd0) ? fhc_pkg::CD_BYPASS_EXIT1 : fhc_pkg::CD_BYPASS_EXIT2;
      end
      fhc_pkg::CMD_SUSPEND: seq_data = fhc_pkg::CD_SUSPEND;
      fhc_pkg::CMD_RESUME: seq_data = fhc_pkg::CD_RESUME;
      default: seq_data = fhc_pkg::CD_RESET;
    endcase
  end

  // only well-formed sequences ever reach the pins, so nothing half-written is left [RL19]
  always_comb begin
    case (cmd_in)
      fhc_pkg::CMD_READ, fhc_pkg::CMD_PROGRAM, fhc_pkg::CMD_HW_RESET: legal = 1'b1;
      fhc_pkg::CMD_BYP_ENTER: legal = !bypass_reg && !suspended_reg;
      fhc_pkg::CMD_BYP_EXIT: legal = bypass_reg;
      fhc_pkg::CMD_CHIP_ERASE, fhc_pkg::CMD_SECTOR_ERASE: legal = !bypass_reg && !suspended_reg;
      fhc_pkg::CMD_RESUME: legal = suspended_reg; // [RL6]
      fhc_pkg::CMD_SW_RESET: legal = !bypass_reg;
      default: legal = 1'b0; // suspend only while an erase is being polled
    endcase
  end

  // handshake and sequencing terms
  assign CMD_READY_O = (state_reg == ST_IDLE) || (state_reg == ST_POLL && erasing_reg && eng_free);
  assign take_idle = (state_reg == ST_IDLE) && CMD_VALID_I && legal;
  assign take_susp = (state_reg == ST_POLL) && CMD_READY_O && CMD_VALID_I &&
                     (cmd_in == fhc_pkg::CMD_SUSPEND); // [RL6]
  assign wr_last = (state_reg == ST_WR) && eng_done && (idx_reg == seq_len - 3'd1);
  assign embedded = (op_reg == fhc_pkg::CMD_PROGRAM) || (op_reg == fhc_pkg::CMD_CHIP_ERASE) ||
                    (op_reg == fhc_pkg::CMD_SECTOR_ERASE) || (op_reg == fhc_pkg::CMD_RESUME) ||
                    (op_reg == fhc_pkg::CMD_SUSPEND);
  assign eng_start = eng_free && ((state_reg == ST_WR) || (state_reg == ST_RD) ||
                     (state_reg == ST_POLL && !pin_mode && !take_susp));
  assign eng_addr = (state_reg == ST_WR) ? seq_addr : addr_reg;
  assign eng_wdata = (op_reg == fhc_pkg::CMD_PROGRAM && idx_reg == seq_len - 3'd1) ?
                     data_reg : {8'h00, seq_data}; // full word on the data cycle [RL10]

  // completion test; program polls for its own bit 7, erase and suspend for a one [RL4]
  always_comb begin
    case (poll_sel_reg)
      fhc_pkg::POLL_PIN: poll_hit = READY_BUSY_N_PIN_I; // [RL4] [RL18]
      fhc_pkg::POLL_DATA: begin
        poll_hit = eng_done && (eng_rdata[fhc_pkg::DATA_POLL_STATUS_BIT] ==
                   ((op_reg == fhc_pkg::CMD_PROGRAM) ? data_reg[fhc_pkg::DATA_POLL_STATUS_BIT]
                                                     : 1'b1));
      end
      fhc_pkg::POLL_TOGGLE: begin
        poll_hit = eng_done && have_prev_reg &&
                   (eng_rdata[fhc_pkg::TOGGLE_STATUS_BIT] == prev_tog_reg);
      end
      default: poll_hit = READY_BUSY_N_PIN_I;
    endcase
  end

  assign fin = (wr_last && !embedded) || (state_reg == ST_POLL && poll_hit) ||
               (state_reg == ST_RD && eng_done) || (state_reg == ST_REC && wait_reg == '0);

  // main sequencer
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_reg <= ST_IDLE;
      op_reg <= fhc_pkg::CMD_READ;
      idx_reg <= 3'd0;
      wait_reg <= '0;
      addr_reg <= '0;
      data_reg <= 16'h0000;
      poll_sel_reg <= fhc_pkg::POLL_PIN;
      reset_n_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take_idle) begin
            op_reg <= cmd_in;
            addr_reg <= CMD_ADDR_I;
            data_reg <= CMD_DATA_I;
            poll_sel_reg <= fhc_pkg::fhc_poll_t'(POLL_SEL_I);
            idx_reg <= 3'd0;
            if (cmd_in == fhc_pkg::CMD_READ) begin
              state_reg <= ST_RD;
            end else if (cmd_in == fhc_pkg::CMD_HW_RESET) begin
              reset_n_reg <= 1'b0; // [RL7]
              wait_reg <= fhc_pkg::RP_CNT - 1'b1;
              state_reg <= ST_RST;
            end else begin
              state_reg <= ST_WR;
            end
          end
        end
        ST_WR: begin
          if (wr_last) begin
            wait_reg <= fhc_pkg::BUSY_CNT - 1'b1; // busy pin settles before first look
            state_reg <= embedded ? ST_PWAIT : ST_IDLE; // [RL2] [RL3]
          end else if (eng_done) begin
            idx_reg <= idx_reg + 3'd1;
          end
        end
        ST_PWAIT: begin
          if (wait_reg == '0) begin
            state_reg <= ST_POLL;
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        ST_POLL: begin
          if (take_susp) begin
            op_reg <= fhc_pkg::CMD_SUSPEND;
            idx_reg <= 3'd0;
            state_reg <= ST_WR;
          end else if (fin) begin
            state_reg <= ST_IDLE; // [RL5]
          end
        end
        ST_RD: begin
          if (fin) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RST: begin
          if (wait_reg == '0) begin
            reset_n_reg <= 1'b1;
            wait_reg <= fhc_pkg::RECOVER_CNT - 1'b1;
            state_reg <= ST_REC;
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        ST_REC: begin
          if (fin) begin
            state_reg <= ST_IDLE; // [RL7]
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // mode tracking; byte mode only changes between commands
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      byte_mode_reg <= 1'b0;
      bypass_reg <= 1'b0;
      suspended_reg <= 1'b0;
      erasing_reg <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE) begin
        byte_mode_reg <= BYTE_MODE_I; // [RL10]
      end
      if (state_reg == ST_RST) begin
        bypass_reg <= 1'b0; // [RL7]
        suspended_reg <= 1'b0;
        erasing_reg <= 1'b0;
      end else if (wr_last && op_reg == fhc_pkg::CMD_BYP_ENTER) begin
        bypass_reg <= 1'b1; // [RL1]
      end else if (wr_last && op_reg == fhc_pkg::CMD_BYP_EXIT) begin
        bypass_reg <= 1'b0;
      end
      if (take_idle && (cmd_in == fhc_pkg::CMD_CHIP_ERASE ||
          cmd_in == fhc_pkg::CMD_SECTOR_ERASE || cmd_in == fhc_pkg::CMD_RESUME)) begin
        erasing_reg <= 1'b1;
        suspended_reg <= 1'b0; // [RL6]
      end else if (take_susp) begin
        erasing_reg <= 1'b0;
      end else if (fin && state_reg == ST_POLL) begin
        erasing_reg <= 1'b0;
        if (op_reg == fhc_pkg::CMD_SUSPEND) begin
          suspended_reg <= 1'b1; // [RL6]
        end
      end
    end
  end

  // status bit history for the toggle method
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      have_prev_reg <= 1'b0;
      prev_tog_reg <= 1'b0;
    end else if (state_reg != ST_POLL) begin
      have_prev_reg <= 1'b0;
    end else if (eng_done) begin
      have_prev_reg <= 1'b1; // [RL4]
      prev_tog_reg <= eng_rdata[fhc_pkg::TOGGLE_STATUS_BIT];
    end
  end

  // user answers
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      done_reg <= fin;
      err_reg <= CMD_VALID_I && CMD_READY_O && !take_idle && !take_susp;
      if (state_reg == ST_RD && eng_done) begin
        rdata_reg <= eng_rdata;
      end
    end
  end

  assign DONE_O = done_reg;
  assign CMD_ERR_O = err_reg;
  assign RDATA_O = rdata_reg;
  assign BUSY_O = (state_reg != ST_IDLE);
  assign BYPASS_O = bypass_reg;
  assign SUSPENDED_O = suspended_reg;
  assign FLASH_RESET_N_O = reset_n_reg;
  assign FLASH_BYTE_N_O = !byte_mode_reg;

  fhc_bus_cycle #(.ADDR_W(ADDR_W)) u_bus (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .start_i(eng_start),
    .write_i(state_reg == ST_WR),
    .byte_mode_i(byte_mode_reg),
    .addr_i(eng_addr),
    .data_i(eng_wdata),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .rdata_o(eng_rdata),
    .ce_n_o(FLASH_CE_N_O),
    .we_n_o(FLASH_WE_N_O),
    .oe_n_o(FLASH_OE_N_O),
    .addr_o(FLASH_ADDR_O),
    .dq_o(DATA_BUS_LINES_O),
    .dq_oe_o(DATA_BUS_LINES_OE_O),
    .dq_i(DATA_BUS_LINES_I)
  );

  // helper counts for the checks below
  logic [2:0] we_cnt_reg;
  logic [fhc_pkg::CNT_W-1:0] rst_low_reg;
  always_ff @(posedge CLK_I) begin
    if (RESET_I || take_idle) begin
      we_cnt_reg <= 3'd0;
      rst_low_reg <= '0;
    end else begin
      if ($fell(FLASH_WE_N_O)) begin
        we_cnt_reg <= we_cnt_reg + 3'd1;
      end
      if (!FLASH_RESET_N_O) begin
        rst_low_reg <= rst_low_reg + 1'b1;
      end
    end
  end

  a_bypass_two_writes: assert property (@(posedge CLK_I) disable iff (RESET_I) // [RL1]
    (state_reg == ST_PWAIT && $past(state_reg) == ST_WR && op_reg == fhc_pkg::CMD_PROGRAM)
    |-> (we_cnt_reg == (bypass_reg ? 3'd2 : 3'd4)))
    else $error("program used wrong number of write cycles");
  a_pin_completion: assert property (@(posedge CLK_I) disable iff (RESET_I) // [RL4]
    (state_reg == ST_POLL && pin_mode && READY_BUSY_N_PIN_I && !take_susp)
    |=> DONE_O && state_reg == ST_IDLE)
    else $error("ready pin did not end the operation");
  a_toggle_completion: assert property (@(posedge CLK_I) disable iff (RESET_I) // [RL4]
    (state_reg == ST_POLL && poll_sel_reg == fhc_pkg::POLL_TOGGLE && eng_done &&
     have_prev_reg && eng_rdata[fhc_pkg::TOGGLE_STATUS_BIT] == prev_tog_reg) |=> DONE_O)
    else $error("steady toggle bit did not end the operation");
  a_strobes_exclusive: assert property (@(posedge CLK_I) disable iff (RESET_I) // [RL14]
    !(!FLASH_WE_N_O && !FLASH_OE_N_O))
    else $error("write and output strobes low together");
  a_strobe_needs_select: assert property (@(posedge CLK_I) disable iff (RESET_I) // [RL14]
    (!FLASH_WE_N_O || !FLASH_OE_N_O || DATA_BUS_LINES_OE_O != 2'h0) |-> !FLASH_CE_N_O)
    else $error("strobe or drive without chip select");
  a_standby_idle: assert property (@(posedge CLK_I) disable iff (RESET_I) // [RL12]
    (state_reg == ST_IDLE || state_reg == ST_PWAIT) |-> FLASH_CE_N_O)
    else $error("chip selected while host is idle");
  a_reset_width: assert property (@(posedge CLK_I) disable iff (RESET_I) // [RL7]
    $rose(FLASH_RESET_N_O) |-> (rst_low_reg == fhc_pkg::RP_CNT))
    else $error("reset pulse width wrong");

  c_bypass_program: cover property (@(posedge CLK_I) disable iff (RESET_I)
    wr_last && op_reg == fhc_pkg::CMD_PROGRAM && bypass_reg);
  c_erase_suspend: cover property (@(posedge CLK_I) disable iff (RESET_I)
    take_susp ##[1:1000] (fin && op_reg == fhc_pkg::CMD_SUSPEND));
  c_hw_reset: cover property (@(posedge CLK_I) disable iff (RESET_I)
    state_reg == ST_REC && fin);
  c_refused: cover property (@(posedge CLK_I) disable iff (RESET_I) CMD_ERR_O);

endmodule // fhc_flash_host
`default_nettype wire

// ===== test/fhc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_model #(parameter int BUSY_T = 40) (
  // strobes, address and data from the host
  input wire logic ce_n_i, we_n_i, oe_n_i, reset_n_i,
  input wire logic [20:0] addr_i,
  input wire logic [15:0] dq_i,
  // read data and ready pin to the host
  output logic [15:0] dq_o,
  output logic ready_busy_n_pin_o
);
  logic [15:0] mem [16];
  logic [15:0] last = '0;
  logic [15:0] rd;
  logic [2:0] n = '0;
  logic prog = 0, byp = 0, tg = 0, pd7 = 0;
  logic [3:0] prot = 4'h8; // top sector locked
  int cnt = 0;
  int i;
  // status while busy; a released bus shows the inverse, never a stale value
  assign rd = (cnt != 0) ? {8'h00, ~pd7, tg, 6'h00} : mem[addr_i[3:0]];
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
  assign ready_busy_n_pin_o = (cnt == 0);
  initial for (i = 0; i < 16; i++) mem[i] = 16'hffff;
  // algorithm timer, self-timed without host help
  always #50 if (cnt > 0) cnt--;
  always @(posedge oe_n_i) last = rd;
  always @(negedge oe_n_i) if (cnt != 0) tg = ~tg;
  // pin reset aborts everything
  always @(negedge reset_n_i) begin
    cnt = 0;
    n = 0;
    prog = 0;
    byp = 0;
  end
  // write strobe rising edge latches address and data
  always @(posedge we_n_i) if (!ce_n_i && reset_n_i && cnt == 0) begin
    if (prog) begin
      if (!prot[addr_i[3:2]]) mem[addr_i[3:0]] = mem[addr_i[3:0]] & dq_i;
      pd7 = dq_i[7];
      prog = 0;
      n = 0;
      cnt = prot[addr_i[3:2]] ? 0 : BUSY_T;
    end else if (byp) begin
      if (dq_i[7:0] == 8'ha0) prog = 1;
      if (dq_i[7:0] == 8'h00) byp = 0;
    end else case ({n, dq_i[7:0]})
      {3'd0, 8'haa}, {3'd1, 8'h55}, {3'd3, 8'haa}, {3'd4, 8'h55}: n = n + 3'd1;
      {3'd2, 8'ha0}: prog = 1;
      {3'd2, 8'h20}: byp = 1;
      {3'd2, 8'h80}: n = 3'd3;
      {3'd5, 8'h10}, {3'd5, 8'h30}: begin
        for (i = 0; i < 16; i++)
          if ((!dq_i[5] || i[3:2] == addr_i[3:2]) && !prot[i[3:2]]) mem[i] = 16'hffff;
        pd7 = 1;
        n = 0;
        cnt = BUSY_T;
      end
      default: n = 0;
    endcase
  end
endmodule // fhc_flash_model
`default_nettype wire

// ===== test/fhc_flash_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_host_tb_top;
  logic clk, rst, vld, rdy, done, err, busy, byp, ce_n, we_n, oe_n, frst_n, ryby, bmode;
  logic [3:0] cmd;
  logic [1:0] psel;
  logic [20:0] addr, faddr;
  logic [15:0] wdat, rdata, dout, din;
  int fail_count = 0, compares = 0, wes = 0, rsts = 0;
  fhc_flash_host DUT (.CLK_I(clk), .RESET_I(rst), .CMD_VALID_I(vld), .CMD_I(cmd),
    .CMD_ADDR_I(addr), .CMD_DATA_I(wdat), .BYTE_MODE_I(bmode), .POLL_SEL_I(psel),
    .CMD_READY_O(rdy), .DONE_O(done), .CMD_ERR_O(err), .RDATA_O(rdata), .BUSY_O(busy),
    .BYPASS_O(byp), .SUSPENDED_O(), .FLASH_CE_N_O(ce_n), .FLASH_WE_N_O(we_n),
    .FLASH_OE_N_O(oe_n), .FLASH_RESET_N_O(frst_n), .FLASH_BYTE_N_O(),
    .FLASH_ADDR_O(faddr), .DATA_BUS_LINES_O(dout), .DATA_BUS_LINES_OE_O(),
    .DATA_BUS_LINES_I(din), .READY_BUSY_N_PIN_I(ryby));
  fhc_flash_model FLASH (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .reset_n_i(frst_n),
    .addr_i(faddr), .dq_i(dout), .dq_o(din), .ready_busy_n_pin_o(ryby));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // write strobe pulse and reset low cycle counters on the flash pins
  always @(negedge we_n) wes++;
  always @(posedge clk) if (frst_n === 1'b0) rsts++;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one command, held until taken, then bounded wait for done or refusal
  task automatic issue(input logic [3:0] c, input logic [20:0] a, input logic [15:0] d,
                       input logic [1:0] p, output logic e);
    int i;
    vld <= 1'b1;
    cmd <= c;
    addr <= a;
    wdat <= d;
    psel <= p;
    do @(posedge clk); while (rdy !== 1'b1);
    vld <= 1'b0;
    for (i = 0; i < 5000 && done !== 1'b1 && err !== 1'b1; i++) @(posedge clk);
    e = err;
    if (i == 5000) chk("command wait", 16'h0, 16'h1);
    @(posedge clk);
  endtask
  task automatic t_prog;
    logic e;
    wes = 0;
    issue(4'h1, 21'h3, 16'h1234, 2'h0, e);
    chk("normal program strobes", 16'd4, 16'(wes));
    issue(4'h0, 21'h3, 16'h0, 2'h0, e);
    chk("read after program", 16'h1234, rdata);
    bmode <= 1'b1;
    issue(4'h0, 21'h3, 16'h0, 2'h0, e);
    chk("byte read", 16'h0034, rdata);
    bmode <= 1'b0;
    $display("program test done");
  endtask
  task automatic t_byp;
    logic e;
    issue(4'h2, 21'h0, 16'h0, 2'h0, e);
    chk("bypass on", 16'h1, {15'h0, byp});
    wes = 0;
    issue(4'h1, 21'h5, 16'h00ff, 2'h1, e);
    chk("bypass program strobes", 16'd2, 16'(wes));
    issue(4'h0, 21'h5, 16'h0, 2'h0, e);
    chk("read after data poll", 16'h00ff, rdata);
    issue(4'h3, 21'h0, 16'h0, 2'h0, e);
    chk("bypass off", 16'h0, {15'h0, byp});
    $display("bypass test done");
  endtask
  task automatic t_erase;
    logic e;
    issue(4'h5, 21'h1, 16'h0, 2'h2, e);
    issue(4'h0, 21'h3, 16'h0, 2'h0, e);
    chk("erased word", 16'hffff, rdata);
    issue(4'h0, 21'h5, 16'h0, 2'h0, e);
    chk("other sector kept", 16'h00ff, rdata);
    issue(4'h1, 21'hc, 16'h0, 2'h0, e);
    issue(4'h0, 21'hc, 16'h0, 2'h0, e);
    chk("locked word kept", 16'hffff, rdata);
    $display("erase test done");
  endtask
  task automatic t_refuse_reset;
    logic e;
    wes = 0;
    issue(4'h7, 21'h0, 16'h0, 2'h0, e);
    chk("resume refused", 16'h1, {15'h0, e});
    chk("no strobes on refusal", 16'h0, 16'(wes));
    rsts = 0;
    issue(4'h9, 21'h0, 16'h0, 2'h0, e);
    chk("reset pulse cycles", 16'(fhc_pkg::RP_CNT), 16'(rsts));
    issue(4'h0, 21'h5, 16'h0, 2'h0, e);
    chk("array read after reset", 16'h00ff, rdata);
    issue(4'h8, 21'h0, 16'h0, 2'h0, e);
    chk("reset command taken", 16'h0, {15'h0, e});
    issue(4'h4, 21'h0, 16'h0, 2'h1, e);
    issue(4'h0, 21'h5, 16'h0, 2'h0, e);
    chk("chip erased", 16'hffff, rdata);
    $display("refusal and reset test done");
  endtask
  initial begin
    rst = 1'b1;
    vld = 1'b0;
    cmd = 4'h0;
    addr = '0;
    wdat = '0;
    psel = 2'h0;
    bmode = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("idle strobes", 16'h000f, {12'h0, ce_n, we_n, oe_n, frst_n});
    t_prog();
    t_byp();
    t_erase();
    t_refuse_reset();
    stop_test();
  end
  // hang guard, well past the expected run
  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end
endmodule // fhc_flash_host_tb_top
`default_nettype wire
